// *** adc_cfg_consts.vh ***
// Constants for the configuration register bank and its serial command port
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

`define CFG0_ADDR        2'h0
`define CFG1_ADDR        2'h1
`define CFG2_ADDR        2'h2
`define CFG3_ADDR        2'h3
`define CFG_RESET_VAL    8'h00

`define RATE_MSB         7
`define RATE_LSB         5
`define OPMODE_MSB       4
`define OPMODE_LSB       3
`define REFSEL_MSB       7
`define REFSEL_LSB       6
`define LINEREJ_MSB      5
`define LINEREJ_LSB      4
`define SWITCH_BIT       3
`define EXC_MSB          2
`define EXC_LSB          0
`define SRCA_MSB         7
`define SRCA_LSB         5
`define SRCB_MSB         4
`define SRCB_LSB         2
`define READY_SEL_BIT    1

`define OPMODE_NORMAL    2'h0
`define OPMODE_DUTY      2'h1
`define OPMODE_TURBO     2'h2
`define RATE_SLOWEST     3'h0
`define RATE_UNUSED      3'h7
`define EXC_OFF          3'h0
`define EXC_UNUSED       3'h1
`define EXC_UNSPEC       3'h3
`define ROUTE_OFF        3'h0
`define ROUTE_UNUSED     3'h7

`define CMD_RESET        8'h06
`define CMD_START        8'h08
`define CMD_SLEEP        8'h02
`define CMD_OP_MASK      8'hF0
`define CMD_READ_OP      8'h20
`define CMD_WRITE_OP     8'h40
`define CMD_ADDR_MSB     3
`define CMD_ADDR_LSB     2

`endif

// *** spi_mode1_slave.v ***
// Byte-wide serial slave: clock idles low, launch on rising edge, sample on falling edge
`timescale 1ns/1ps
module spi_mode1_slave (
  input  wire       mclk,
  input  wire       rst,
  input  wire       sclk_pin,
  input  wire       cs_n_pin,
  input  wire       din_pin,
  input  wire       tx_load,
  input  wire [7:0] tx_byte,
  output reg  [7:0] rx_byte_q,
  output reg        rx_valid_q,
  output reg        frame_start_q,
  output reg        dout_q,
  output wire       selected
);
  reg [2:0] sclk_s1_q, sclk_s2_q;
  reg       sclk_prev_q;
  reg [7:0] rx_shift_q;
  reg [7:0] tx_shift_q;
  reg [2:0] bit_cnt_q;
  reg       cs_prev_q;
  wire      sclk_s;
  wire      cs_n_s;
  wire      din_s;
  wire      rise;
  wire      fall;

  // Pin inputs cross into mclk through two flops each; only the second stage is read
  // Reset to the idle pin levels (clock low, select high) so no false frame follows reset
  always @(posedge mclk) begin
    if (rst) begin
      sclk_s1_q <= 3'h3;
      sclk_s2_q <= 3'h3;
    end else begin
      sclk_s1_q <= {sclk_pin, cs_n_pin, din_pin};
      sclk_s2_q <= sclk_s1_q;
    end
  end

  assign sclk_s   = sclk_s2_q[2];
  assign cs_n_s   = sclk_s2_q[1];
  assign din_s    = sclk_s2_q[0];
  assign selected = ~cs_n_s;
  assign rise     = selected & sclk_s & ~sclk_prev_q;
  assign fall     = selected & ~sclk_s & sclk_prev_q;

  always @(posedge mclk) begin
    if (rst) begin
      sclk_prev_q   <= 1'b0;
      cs_prev_q     <= 1'b1;
      rx_shift_q    <= 8'h00;
      tx_shift_q    <= 8'h00;
      bit_cnt_q     <= 3'h0;
      rx_byte_q     <= 8'h00;
      rx_valid_q    <= 1'b0;
      frame_start_q <= 1'b0;
      dout_q        <= 1'b0;
    end else begin
      sclk_prev_q   <= sclk_s;
      cs_prev_q     <= cs_n_s;
      rx_valid_q    <= 1'b0;
      frame_start_q <= cs_prev_q & ~cs_n_s;
      if (!selected) begin
        bit_cnt_q  <= 3'h0;
        tx_shift_q <= 8'h00;
      end else begin
        if (rise) begin
          dout_q     <= tx_shift_q[7];
          tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        end else if (tx_load) begin
          tx_shift_q <= tx_byte;
        end
        if (fall) begin
          rx_shift_q <= {rx_shift_q[6:0], din_s};
          bit_cnt_q  <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            rx_byte_q  <= {rx_shift_q[6:0], din_s};
            rx_valid_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule // spi_mode1_slave

// *** adc_config_reg_bank.v ***
// Configuration register bank with serial command port and decoded analog controls
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"
module adc_config_reg_bank #(
  parameter DESTS = 6
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             sclk_pin,
  input  wire             cs_n_pin,
  input  wire             din_pin,
  input  wire             new_data,
  output reg              serial_out_ready_pin_q,
  output reg              serial_out_oe_q,
  output reg              data_ready_pin_n_q,
  output reg  [1:0]       reference_select_q,
  output reg  [1:0]       line_rejection_q,
  output reg              low_side_switch_closed_q,
  output reg  [2:0]       excitation_current_level_q,
  output reg              excitation_on_q,
  output reg  [DESTS-1:0] excitation_source_a_q,
  output reg  [DESTS-1:0] excitation_source_b_q,
  output reg  [2:0]       sample_rate_code_q,
  output reg  [1:0]       op_mode_q,
  output reg              rate_valid_q,
  output reg              converting_q
);
  localparam ST_CMD   = 3'b001;
  localparam ST_READ  = 3'b010;
  localparam ST_WRITE = 3'b100;

  reg  [7:0] cfg0_q, cfg1_q, cfg2_q, cfg3_q;
  reg  [2:0] state_q;
  reg  [1:0] addr_q;
  reg  [7:0] rd_data;
  reg        low_side_switch_ctrl;
  reg        tx_load;
  reg        ready_pending_q;
  wire [7:0] rx_byte;
  wire       rx_valid;
  wire       frame_start;
  wire       dout_bit;
  wire       selected;
  wire [1:0] cmd_addr;
  wire [2:0] source_a_routing;
  wire [2:0] source_b_routing;
  wire       exc_level_valid;
  wire       ready_signal_select;

  spi_mode1_slave u_spi (
    .mclk          (mclk),
    .rst           (rst),
    .sclk_pin      (sclk_pin),
    .cs_n_pin      (cs_n_pin),
    .din_pin       (din_pin),
    .tx_load       (tx_load),
    .tx_byte       (rd_data),
    .rx_byte_q     (rx_byte),
    .rx_valid_q    (rx_valid),
    .frame_start_q (frame_start),
    .dout_q        (dout_bit),
    .selected      (selected)
  );

  assign cmd_addr            = rx_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  assign source_a_routing    = cfg3_q[`SRCA_MSB:`SRCA_LSB];
  assign source_b_routing    = cfg3_q[`SRCB_MSB:`SRCB_LSB];
  assign ready_signal_select = cfg3_q[`READY_SEL_BIT];

  always @* begin
    rd_data = `CFG_RESET_VAL;
    case (cmd_addr)
      `CFG0_ADDR: rd_data = cfg0_q;
      `CFG1_ADDR: rd_data = cfg1_q;
      `CFG2_ADDR: rd_data = cfg2_q;
      `CFG3_ADDR: rd_data = cfg3_q;
      default:    rd_data = `CFG_RESET_VAL;
    endcase
  end

  always @* begin
    tx_load = rx_valid && (state_q == ST_CMD) && ((rx_byte & `CMD_OP_MASK) == `CMD_READ_OP);
  end

  // Command and register write engine; one register per read or write command
  always @(posedge mclk) begin
    if (rst) begin
      cfg0_q  <= `CFG_RESET_VAL;
      cfg1_q  <= `CFG_RESET_VAL;
      cfg2_q  <= `CFG_RESET_VAL;
      cfg3_q  <= `CFG_RESET_VAL;
      state_q <= ST_CMD;
      addr_q  <= `CFG0_ADDR;
      converting_q <= 1'b0;
    end else if (!selected) begin
      state_q <= ST_CMD;
    end else if (rx_valid) begin
      case (state_q)
        ST_CMD: begin
          addr_q <= cmd_addr;
          if (rx_byte == `CMD_RESET) begin
            cfg0_q <= `CFG_RESET_VAL;
            cfg1_q <= `CFG_RESET_VAL;
            cfg2_q <= `CFG_RESET_VAL;
            cfg3_q <= `CFG_RESET_VAL;
            converting_q <= 1'b0;
          end else if (rx_byte == `CMD_START) begin
            converting_q <= 1'b1;
          end else if (rx_byte == `CMD_SLEEP) begin
            converting_q <= 1'b0;
          end else if ((rx_byte & `CMD_OP_MASK) == `CMD_READ_OP) begin
            state_q <= ST_READ;
          end else if ((rx_byte & `CMD_OP_MASK) == `CMD_WRITE_OP) begin
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          state_q <= ST_CMD;
          case (addr_q)
            `CFG0_ADDR: cfg0_q <= rx_byte;
            `CFG1_ADDR: cfg1_q <= rx_byte;
            `CFG2_ADDR: cfg2_q <= rx_byte;
            `CFG3_ADDR: cfg3_q <= rx_byte;
            default:    cfg0_q <= cfg0_q;
          endcase
        end
        ST_READ: state_q <= ST_CMD;
        default: state_q <= ST_CMD;
      endcase
    end
  end

  // Switch follows start and sleep only while automatic mode is enabled
  always @* begin
    low_side_switch_ctrl = cfg2_q[`SWITCH_BIT] & converting_q;
  end

  assign exc_level_valid = (cfg2_q[`EXC_MSB:`EXC_LSB] != `EXC_OFF) &&
                           (cfg2_q[`EXC_MSB:`EXC_LSB] != `EXC_UNUSED) &&
                           (cfg2_q[`EXC_MSB:`EXC_LSB] != `EXC_UNSPEC);

  // Routing code n+1 selects destination n: in0, in1, in2, in3, dedicated pos, dedicated neg
  genvar i;
  generate
    for (i = 0; i < DESTS; i = i + 1) begin : g_route
      always @(posedge mclk) begin
        if (rst) begin
          excitation_source_a_q[i] <= 1'b0;
          excitation_source_b_q[i] <= 1'b0;
        end else begin
          excitation_source_a_q[i] <= exc_level_valid && (source_a_routing == i + 1);
          excitation_source_b_q[i] <= exc_level_valid && (source_b_routing == i + 1);
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (rst) begin
      reference_select_q         <= 2'h0;
      line_rejection_q           <= 2'h0;
      low_side_switch_closed_q   <= 1'b0;
      excitation_current_level_q <= `EXC_OFF;
      excitation_on_q            <= 1'b0;
      sample_rate_code_q         <= `RATE_SLOWEST;
      op_mode_q                  <= `OPMODE_NORMAL;
      rate_valid_q               <= 1'b0;
    end else begin
      reference_select_q <= cfg2_q[`REFSEL_MSB:`REFSEL_LSB];
      // Coefficients only matter in the slowest column entries
      if (cfg1_q[`RATE_MSB:`RATE_LSB] == `RATE_SLOWEST &&
          (cfg1_q[`OPMODE_MSB:`OPMODE_LSB] == `OPMODE_NORMAL ||
           cfg1_q[`OPMODE_MSB:`OPMODE_LSB] == `OPMODE_DUTY)) begin
        line_rejection_q <= cfg2_q[`LINEREJ_MSB:`LINEREJ_LSB];
      end else begin
        line_rejection_q <= 2'h0;
      end
      low_side_switch_closed_q   <= low_side_switch_ctrl;
      excitation_current_level_q <= exc_level_valid ? cfg2_q[`EXC_MSB:`EXC_LSB] : `EXC_OFF;
      excitation_on_q            <= exc_level_valid;
      // Code is handed to the converter as is; its period counts conversion clocks, so rates scale with it
      sample_rate_code_q <= cfg1_q[`RATE_MSB:`RATE_LSB];
      op_mode_q          <= cfg1_q[`OPMODE_MSB:`OPMODE_LSB];
      rate_valid_q       <= (cfg1_q[`RATE_MSB:`RATE_LSB] != `RATE_UNUSED) &&
                            (cfg1_q[`OPMODE_MSB:`OPMODE_LSB] != 2'h3);
    end
  end

  // Ready indication: new data wins over the clear at frame start
  always @(posedge mclk) begin
    if (rst) begin
      ready_pending_q        <= 1'b0;
      data_ready_pin_n_q     <= 1'b1;
      serial_out_ready_pin_q <= 1'b1;
      serial_out_oe_q        <= 1'b0;
    end else begin
      if (new_data) begin
        ready_pending_q <= 1'b1;
      end else if (frame_start) begin
        ready_pending_q <= 1'b0;
      end
      data_ready_pin_n_q <= ~(new_data | (ready_pending_q & ~frame_start));
      serial_out_oe_q    <= selected;
      if (selected && ready_signal_select && state_q == ST_CMD && !tx_load && !ready_pending_q) begin
        serial_out_ready_pin_q <= 1'b1;
      end else if (selected && ready_signal_select && state_q == ST_CMD && ready_pending_q) begin
        serial_out_ready_pin_q <= 1'b0;
      end else begin
        serial_out_ready_pin_q <= dout_bit;
      end
    end
  end
endmodule // adc_config_reg_bank

// *** adc_config_reg_bank_asserts.sv ***
// Concurrent checks on the register bank's decoded outputs and ready signalling
`timescale 1ns/1ps
module adc_config_reg_bank_asserts #(
  parameter DESTS = 6
) (
  input wire             mclk,
  input wire             rst,
  input wire             cs_n_pin,
  input wire             new_data,
  input wire             serial_out_oe_q,
  input wire             data_ready_pin_n_q,
  input wire [1:0]       reference_select_q,
  input wire [1:0]       line_rejection_q,
  input wire             low_side_switch_closed_q,
  input wire [2:0]       excitation_current_level_q,
  input wire             excitation_on_q,
  input wire [DESTS-1:0] excitation_source_a_q,
  input wire [DESTS-1:0] excitation_source_b_q,
  input wire [2:0]       sample_rate_code_q,
  input wire [1:0]       op_mode_q,
  input wire             rate_valid_q,
  input wire             converting_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_clears_all: assert property (disable iff (1'b0) rst |=> data_ready_pin_n_q && !converting_q
    && reference_select_q == 2'h0 && excitation_source_a_q == '0) else $error("outputs not cleared by reset");
  a_rejection_rate_gate: assert property (line_rejection_q != 2'h0
    |-> sample_rate_code_q == 3'h0 && !op_mode_q[1]) else $error("line rejection at wrong rate");
  // Decode stage lags reset by a cycle, so give it two clean edges first
  a_rate_code_valid: assert property (!$past(rst, 2) && !$past(rst)
    |-> rate_valid_q == (sample_rate_code_q != 3'h7 && op_mode_q != 2'h3)) else $error("rate valid wrong");
  a_excitation_on_level: assert property (excitation_on_q == (excitation_current_level_q != 3'h0))
    else $error("excitation enable disagrees with level");
  a_source_a_route: assert property ($onehot0(excitation_source_a_q)
    && (excitation_on_q || excitation_source_a_q == '0)) else $error("source a routing wrong");
  a_source_b_route: assert property ($onehot0(excitation_source_b_q)
    && (excitation_on_q || excitation_source_b_q == '0)) else $error("source b routing wrong");
  a_switch_needs_conv: assert property (!converting_q [*2] |-> !low_side_switch_closed_q)
    else $error("switch closed while idle");
  a_ready_set_pulse: assert property (new_data |=> !data_ready_pin_n_q)
    else $error("ready not raised after new data");
  a_ready_holds_idle: assert property (cs_n_pin [*6] ##0 !data_ready_pin_n_q |=> !data_ready_pin_n_q)
    else $error("ready dropped without frame start");
  a_oe_when_selected: assert property (!cs_n_pin [*5] |-> serial_out_oe_q)
    else $error("serial out not driven while selected");
  a_oe_off_released: assert property (cs_n_pin [*5] |-> !serial_out_oe_q)
    else $error("serial out driven while released");
  c_ready: cover property (new_data ##1 !data_ready_pin_n_q);
  c_rejection: cover property (line_rejection_q != 2'h0);
  c_switch: cover property (low_side_switch_closed_q);
  c_rate_bad: cover property (!rate_valid_q);
endmodule // adc_config_reg_bank_asserts

bind adc_config_reg_bank adc_config_reg_bank_asserts #(.DESTS(DESTS)) u_adc_config_reg_bank_asserts (
  .mclk                       (mclk),
  .rst                        (rst),
  .cs_n_pin                   (cs_n_pin),
  .new_data                   (new_data),
  .serial_out_oe_q            (serial_out_oe_q),
  .data_ready_pin_n_q         (data_ready_pin_n_q),
  .reference_select_q         (reference_select_q),
  .line_rejection_q           (line_rejection_q),
  .low_side_switch_closed_q   (low_side_switch_closed_q),
  .excitation_current_level_q (excitation_current_level_q),
  .excitation_on_q            (excitation_on_q),
  .excitation_source_a_q      (excitation_source_a_q),
  .excitation_source_b_q      (excitation_source_b_q),
  .sample_rate_code_q         (sample_rate_code_q),
  .op_mode_q                  (op_mode_q),
  .rate_valid_q               (rate_valid_q),
  .converting_q               (converting_q)
);

// *** spi_host_model.sv ***
// Serial host model: mode 1 master that frames bytes and samples the read-back line
`timescale 1ns/1ps
module spi_host_model (
  output reg  sclk,
  output reg  cs_n,
  output reg  din,
  input  wire dout,
  input  wire oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end
  task sel(input bit on);
    #160 cs_n = !on;
    if (!on)
      din = !din; // Released line must not keep its last bit
  endtask
  // Clock idles low between frames and only toggles inside them
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din  = tx[i];
      #160 sclk = 1'b0;
      rx[i] = oe ? dout : 1'bx;
      #160;
    end
  endtask
endmodule // spi_host_model

// *** test_adc_config_reg_bank.sv ***
// Self-checking bench for the configuration register bank over its serial port
`timescale 1ns/1ps
module test_adc_config_reg_bank;
  reg         mclk     = 1'b0;
  reg         rst      = 1'b1;
  reg         new_data = 1'b0;
  wire        sclk, cs_n, din, dout, oe, rdy_n, sw, exc_on, rv, conv;
  wire [1:0]  refs, rej, mode;
  wire [2:0]  lvl, rate;
  wire [5:0]  src_a, src_b;
  reg  [7:0]  rx;
  integer     bad_count = 0;
  integer     n_tests   = 0;
  integer     cyc       = 0;
  integer     i;
  always #20 mclk = !mclk;
  adc_config_reg_bank #(.DESTS(6)) u_adc_config_reg_bank (.mclk(mclk), .rst(rst), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .din_pin(din), .new_data(new_data), .serial_out_ready_pin_q(dout),
    .serial_out_oe_q(oe), .data_ready_pin_n_q(rdy_n), .reference_select_q(refs), .line_rejection_q(rej),
    .low_side_switch_closed_q(sw), .excitation_current_level_q(lvl), .excitation_on_q(exc_on),
    .excitation_source_a_q(src_a), .excitation_source_b_q(src_b), .sample_rate_code_q(rate),
    .op_mode_q(mode), .rate_valid_q(rv), .converting_q(conv));
  spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .oe(oe));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task cmd(input [7:0] c0, input [7:0] c1, input bit two);
    u_spi_host_model.sel(1);
    u_spi_host_model.xfer(c0, rx);
    if (two)
      u_spi_host_model.xfer(c1, rx);
    u_spi_host_model.sel(0);
    tick(8);
  endtask
  task wr(input [1:0] a, input [7:0] d);
    cmd(8'h40 | {4'h0, a, 2'h0}, d, 1);
  endtask
  task rd(input [1:0] a, input [7:0] e);
    cmd(8'h20 | {4'h0, a, 2'h0}, 8'h00, 1);
    chk("readback", e, rx);
  endtask
  task pulse;
    new_data = 1'b1;
    tick(1);
    new_data = 1'b0;
    tick(1);
  endtask
  function [7:0] oh(input [2:0] c);
    oh = (c == 3'h0 || c == 3'h7) ? 8'h00 : 8'h01 << (c - 3'h1);
  endfunction
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the roughly 12300 cycles the sequence needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    tick(6);
    rst = 1'b0;
    tick(4);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    chk("ready_n", 8'h01, {7'h0, rdy_n});
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr(2'h2, {i[1:0], 6'h00});
      chk("refsel", i, {6'h0, refs});
      rd(2'h2, {i[1:0], 6'h00});
      wr(2'h2, {2'h0, i[1:0], 4'h0});
      chk("rejection", i, {6'h0, rej});
    end
    $display("test reference and rejection done");
    for (i = 0; i < 32; i++) begin
      wr(2'h1, {i[4:0], 3'h0});
      chk("rate", i[4:2], {5'h0, rate});
      chk("mode", i[1:0], {6'h0, mode});
      chk("rate_valid", i[4:2] != 3'h7 && i[1:0] != 2'h3, {7'h0, rv});
      chk("rej_gate", (i[4:2] == 3'h0 && !i[1]) ? 8'h03 : 8'h00, {6'h0, rej});
    end
    $display("test rate codes done");
    for (i = 0; i < 8; i++) begin
      wr(2'h2, {5'h00, i[2:0]});
      chk("level", (i == 0 || i == 1 || i == 3) ? 8'h00 : i, {5'h0, lvl});
      chk("exc_on", !(i == 0 || i == 1 || i == 3), {7'h0, exc_on});
    end
    for (i = 0; i < 8; i++) begin
      wr(2'h3, {i[2:0], 3'h7 - i[2:0], 2'h0});
      chk("source_a", oh(i[2:0]), {2'h0, src_a});
      chk("source_b", oh(3'h7 - i[2:0]), {2'h0, src_b});
      rd(2'h3, {i[2:0], 3'h7 - i[2:0], 2'h0});
    end
    wr(2'h2, 8'h00);
    chk("source_off", 8'h00, {2'h0, src_a});
    $display("test excitation done");
    wr(2'h2, 8'h08);
    cmd(8'h08, 8'h00, 0);
    chk("switch_on", 8'h01, {7'h0, sw});
    cmd(8'h02, 8'h00, 0);
    chk("switch_off", 8'h00, {6'h0, sw, conv});
    wr(2'h2, 8'h00);
    cmd(8'h08, 8'h00, 0);
    chk("switch_kept", 8'h01, {6'h0, sw, conv});
    cmd(8'h02, 8'h00, 0);
    $display("test switch done");
    wr(2'h3, 8'h02);
    u_spi_host_model.sel(1);
    tick(6);
    chk("ready_idle_dout", 8'h01, {7'h0, dout});
    pulse;
    chk("ready_pin", 8'h00, {7'h0, rdy_n});
    tick(2);
    chk("ready_on_dout", 8'h00, {7'h0, dout});
    u_spi_host_model.sel(0);
    tick(8);
    chk("ready_held", 8'h00, {7'h0, rdy_n});
    u_spi_host_model.sel(1);
    tick(8);
    chk("ready_cleared", 8'h01, {7'h0, rdy_n});
    u_spi_host_model.sel(0);
    wr(2'h3, 8'h00);
    pulse;
    chk("ready_only_pin", 8'h00, {7'h0, rdy_n});
    $display("test ready done");
    // Second reset in mid-run, then the reset command, both must bring the registers back to 00h
    wr(2'h2, 8'hC8);
    wr(2'h3, 8'hFE);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    chk("ready_after_reset", 8'h01, {7'h0, rdy_n});
    wr(2'h0, 8'h5A);
    rd(2'h0, 8'h5A);
    cmd(8'h08, 8'h00, 0);
    cmd(8'h06, 8'h00, 0);
    chk("reset_cmd_conv", 8'h00, {7'h0, conv});
    rd(2'h0, 8'h00);
    $display("test reset again done");
    complete_run;
  end
endmodule // test_adc_config_reg_bank
